//--- core/host_control_port_params.svh
// constants of the host control port: offsets, field positions, reset values, timing
// assumes it is included by bare name from the core module
`ifndef HOST_CONTROL_PORT_PARAMS_SVH
`define HOST_CONTROL_PORT_PARAMS_SVH

// ****************************************
// register offsets (low eight address bits)
// ****************************************
`define OFS_SOFT_RESET     8'h04
`define OFS_GEN_PIN        8'h06
`define OFS_CHAN_SUMMARY   8'h09
`define OFS_LINE_STD       8'h20
`define OFS_IRQ_EN_FIRST   8'h33
`define OFS_IRQ_EN_SECOND  8'h34
`define OFS_EDGE_SEL       8'h35
`define OFS_LIVE_FIRST     8'h36
`define OFS_LIVE_SECOND    8'h37
`define OFS_LATCH_FIRST    8'h3A
`define OFS_LATCH_SECOND   8'h3B
`define GLOBAL_LIMIT       8'h20

// ****************************************
// field positions
// ****************************************
`define GP_PIN0_DIRECTION_BIT        0
`define GP_PIN1_DIRECTION_BIT        1
`define GP_LVL0_BIT        2
`define GP_LVL1_BIT        3
`define EQ_LIVE_BIT        0
`define EQ_LATCH_BIT       7
`define LINE_STD_BIT       0

// ****************************************
// reset values
// ****************************************
`define RST_GEN_PIN        4'h0
`define RST_LINE_STD       1'b0
`define RST_IRQ_EN         8'h00
`define RST_EDGE_SEL       8'h00

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS      40
`define SOFT_RESET_NS      1000
`define SOFT_RESET_CYC     ((`SOFT_RESET_NS) / (`CLK_PERIOD_NS))
`define SETTLE_NS          50000
`define SETTLE_CYC         ((`SETTLE_NS) / (`CLK_PERIOD_NS))

`endif

//--- core/host_control_port_pkg.sv
// types shared by the host control port
// assumes the params header sits in the include path
package host_control_port_pkg;

  // per-channel event sources coming from the line logic on CLOCK
  typedef struct packed {
    logic [7:0] live_first;
    logic [7:0] live_second;
    logic [6:0] pulse_second;
  } chan_evt_s;

  // host pins (straps, parallel bus, general pins), synchronised as one group
  typedef struct packed {
    logic        serial_port_select;
    logic        parallel_style_select;
    logic        cs_n;
    logic        strobe_n;
    logic        rw_wr;
    logic [10:0] addr;
    logic [7:0]  data;
    logic [1:0]  gen_pin;
  } pin_group_s;

  typedef enum logic [2:0] {
    P_IDLE  = 3'b001,
    P_READ  = 3'b010,
    P_WRITE = 3'b100
  } par_state_e;

endpackage

//--- core/host_control_port.sv
// host control port: serial and parallel register access, interrupt merge, general pins, resets
// assumes channel event inputs are on CLOCK; all host pins are asynchronous to CLOCK
//
// Functional notes
// - serial select pin high chooses serial port
// - chip select frames each serial transaction
// - two header bytes sampled on rising edges
// - header msb one reads, zero writes
// - read data shifts out on falling edges
// - write data byte follows low address byte
// - style pin picks strobe or read/write style
// - eleven-bit address, separate eight-bit data bus
// - request pin active while any channel pending
// - events latched, each event type enabled separately
// - edge select decides which live transition latches
// - reading latch register clears channel summary bit
// - request and summary clear when nothing pending
// - fifteen source kinds per channel
// - live events have edge select; others pulse
// - two general pins with own direction bits
// - input pin level read back in level bit
// - output pin driven from level bit
// - any soft reset write resets within 1 us
// - reset hi-z drivers, defaults; soft keeps standard
// - global registers shared, channel registers per channel
`include "host_control_port_params.svh"
`timescale 1ns/1ns
`default_nettype none

module host_control_port
  import host_control_port_pkg::*;
#(
  parameter int CHANNELS      = 8,
  parameter int SETTLE_CYCLES = `SETTLE_CYC
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RESET_N,
  input  wire logic                  CE,
  input  wire logic                  SERIAL_SEL,
  input  wire logic                  STYLE_SEL,
  input  wire logic                  SCLK,
  input  wire logic                  CS_N,
  input  wire logic                  SDI,
  output var  logic                  SDO,
  output var  logic                  SDO_OE,
  input  wire logic                  PCS_N,
  input  wire logic                  STROBE_N,
  input  wire logic                  RW_WR,
  input  wire logic [10:0]           ADDR,
  input  wire logic [7:0]            D_IN,
  output var  logic [7:0]            D_OUT,
  output var  logic                  D_OE,
  output var  logic                  IRQ_N,
  input  wire logic [1:0]            GEN_PIN_IN,
  output var  logic [1:0]            GEN_PIN_OUT,
  output var  logic [1:0]            GEN_PIN_OE,
  input  wire chan_evt_s [7:0]       CHAN_EVT,
  output var  logic [7:0]            LINE_STD,
  output var  logic                  DRIVER_HIZ
);

  generate
    if (CHANNELS < 1 || CHANNELS > 8 || SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_param
      $error("host_control_port: CHANNELS must be 1..8, SETTLE_CYCLES 1..65535");
    end
  endgenerate

  localparam logic [5:0] SRST_CYC = 6'(`SOFT_RESET_CYC);

  // ****************************************
  // serial link, SCLK domain
  // ****************************************
  // chip select high clears the frame; address and data stay for the core
  logic [4:0]  bit_cnt_q;
  logic [6:0]  sin_q;
  logic        s_rw_q;
  logic [10:0] s_addr_q;
  logic [7:0]  s_wdata_q;
  logic        s_rd_req_q;
  logic        s_wr_req_q;
  logic        s_ack1_q;
  logic        s_ack2_q;
  logic [6:0]  sout_q;
  logic        sout_loaded_q;
  logic [7:0]  rd_data_q;
  logic        rd_ack_q;

  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt_q  <= 5'h00;
      sin_q      <= 7'h00;
      s_rw_q     <= 1'b0;
      s_rd_req_q <= 1'b0;
      s_wr_req_q <= 1'b0;
    end else begin
      if (bit_cnt_q != 5'd24) begin
        bit_cnt_q <= bit_cnt_q + 5'd1;
      end
      sin_q <= {sin_q[5:0], SDI};
      if (bit_cnt_q == 5'd7) begin
        s_rw_q         <= sin_q[6];
        s_addr_q[10:8] <= {sin_q[1:0], SDI};
      end
      if (bit_cnt_q == 5'd15) begin
        s_addr_q[7:0] <= {sin_q, SDI};
        s_rd_req_q    <= s_rw_q;
      end
      if (bit_cnt_q == 5'd23 && !s_rw_q) begin
        s_wdata_q  <= {sin_q, SDI};
        s_wr_req_q <= 1'b1;
      end
    end
  end

  // read answer comes back from the core as a level handshake
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      s_ack1_q <= 1'b0;
      s_ack2_q <= 1'b0;
    end else begin
      s_ack1_q <= rd_ack_q;
      s_ack2_q <= s_ack1_q;
    end
  end

  // read data waits one turnaround byte
  // so the answer can cross domains
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      SDO           <= 1'b0;
      SDO_OE        <= 1'b0;
      sout_q        <= 7'h00;
      sout_loaded_q <= 1'b0;
    end else if (!sout_loaded_q && bit_cnt_q == 5'd24 && s_rw_q) begin
      SDO           <= s_ack2_q & rd_data_q[7];
      sout_q        <= s_ack2_q ? rd_data_q[6:0] : 7'h00;
      SDO_OE        <= 1'b1;
      sout_loaded_q <= 1'b1;
    end else if (sout_loaded_q) begin
      SDO    <= sout_q[6];
      sout_q <= {sout_q[5:0], 1'b0};
    end
  end

  // ****************************************
  // pin synchronisers, CLOCK domain
  // ****************************************
  pin_group_s pin_s1_q;
  pin_group_s pin_s2_q;
  pin_group_s pin_now;
  logic [2:0] rd_req_sync_q;
  logic [2:0] wr_req_sync_q;

  assign pin_now = '{serial_port_select: SERIAL_SEL, parallel_style_select: STYLE_SEL,
                     cs_n: PCS_N, strobe_n: STROBE_N, rw_wr: RW_WR, addr: ADDR,
                     data: D_IN, gen_pin: GEN_PIN_IN};

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      pin_s1_q      <= '0;
      pin_s2_q      <= '0;
      rd_req_sync_q <= 3'h0;
      wr_req_sync_q <= 3'h0;
    end else if (CE) begin
      pin_s1_q      <= pin_now;
      pin_s2_q      <= pin_s1_q;
      rd_req_sync_q <= {rd_req_sync_q[1:0], s_rd_req_q};
      wr_req_sync_q <= {wr_req_sync_q[1:0], s_wr_req_q};
    end
  end

  // ****************************************
  // reset sequencing
  // ****************************************
  logic [5:0]  srst_cnt_q;
  logic [15:0] settle_cnt_q;
  logic        core_rst;
  logic        acc_rd;
  logic        acc_wr;
  logic [10:0] acc_addr;
  logic [7:0]  acc_data;
  logic        glob_hit;

  assign core_rst = !RESET_N || (srst_cnt_q != 6'h00);
  assign glob_hit = (acc_addr[10:8] == 3'h0) && (acc_addr[7:0] < `GLOBAL_LIMIT);

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      srst_cnt_q <= 6'h00;
    end else if (CE) begin
      if (srst_cnt_q != 6'h00) begin
        srst_cnt_q <= srst_cnt_q - 6'h01;
      end else if (acc_wr && glob_hit && acc_addr[7:0] == `OFS_SOFT_RESET) begin
        srst_cnt_q <= SRST_CYC;
      end
    end
  end

  // drivers stay off until clocking settles
  always_ff @(posedge CLOCK) begin
    if (core_rst) begin
      settle_cnt_q <= 16'h0000;
      DRIVER_HIZ   <= 1'b1;
    end else if (CE) begin
      if (settle_cnt_q != 16'(SETTLE_CYCLES)) begin
        settle_cnt_q <= settle_cnt_q + 16'h0001;
      end else begin
        DRIVER_HIZ <= 1'b0;
      end
    end
  end

  // ****************************************
  // access selection
  // ****************************************
  par_state_e  par_state_q;
  logic        par_rd;
  logic        par_wr;
  logic [10:0] par_addr_q;
  logic [7:0]  par_data_q;
  logic        serial_mode;

  assign serial_mode = pin_s2_q.serial_port_select;
  always_comb begin
    if (pin_s2_q.parallel_style_select) begin
      par_rd = !pin_s2_q.cs_n && !pin_s2_q.strobe_n;
      par_wr = !pin_s2_q.cs_n && !pin_s2_q.rw_wr;
    end else begin
      par_rd = !pin_s2_q.cs_n && !pin_s2_q.strobe_n && pin_s2_q.rw_wr;
      par_wr = !pin_s2_q.cs_n && !pin_s2_q.strobe_n && !pin_s2_q.rw_wr;
    end
  end

  always_comb begin
    if (serial_mode) begin
      acc_rd   = rd_req_sync_q[1] && !rd_req_sync_q[2];
      acc_wr   = wr_req_sync_q[1] && !wr_req_sync_q[2];
      acc_addr = s_addr_q;
      acc_data = s_wdata_q;
    end else begin
      acc_rd   = (par_state_q == P_IDLE) && par_rd;
      acc_wr   = (par_state_q == P_WRITE) && !par_wr;
      acc_addr = acc_rd ? pin_s2_q.addr : par_addr_q;
      acc_data = par_data_q;
    end
  end

  // parallel write lands when the strobe ends
  always_ff @(posedge CLOCK) begin
    if (core_rst) begin
      par_state_q <= P_IDLE;
      par_addr_q  <= 11'h000;
      par_data_q  <= 8'h00;
      D_OE        <= 1'b0;
    end else if (CE) begin
      case (par_state_q)
        P_IDLE: begin
          if (!serial_mode && par_rd) begin
            par_state_q <= P_READ;
            D_OE        <= 1'b1;
          end else if (!serial_mode && par_wr) begin
            par_state_q <= P_WRITE;
            par_addr_q  <= pin_s2_q.addr;
            par_data_q  <= pin_s2_q.data;
          end
        end
        P_READ: begin
          if (!par_rd) begin
            par_state_q <= P_IDLE;
            D_OE        <= 1'b0;
          end
        end
        P_WRITE: begin
          if (par_wr) begin
            par_addr_q <= pin_s2_q.addr;
            par_data_q <= pin_s2_q.data;
          end else begin
            par_state_q <= P_IDLE;
          end
        end
        default: begin
          par_state_q <= P_IDLE;
          D_OE        <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] en_first_q [8];
  logic [7:0] en_second_q [8];
  logic [7:0] edge_sel_q [8];
  logic [7:0] live1_prev_q [8];
  logic [7:0] live2_prev_q [8];
  logic [7:0] latch_first_q [8];
  logic [7:0] latch_second_q [8];
  logic [7:0] line_std_q;
  logic [3:0] gen_pin_q;
  logic [7:0] summary_q;
  logic [7:0] ev_first [8];
  logic [7:0] ev_second [8];
  logic [7:0] pend;
  logic [7:0] new_ev;
  logic [7:0] rd_clr;
  logic [7:0] ch_sel;
  logic [7:0] rd_val;
  logic [1:0] gp_level;

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      ch_sel[c] = (acc_addr[10:8] == 3'(c)) && (c < CHANNELS);
      // edge select low latches on rise, high on fall
      ev_first[c] = (edge_sel_q[c] & live1_prev_q[c] & ~CHAN_EVT[c].live_first)
                  | (~edge_sel_q[c] & ~live1_prev_q[c] & CHAN_EVT[c].live_first);
      ev_first[c][7] = 1'b0;
      ev_second[c] = {1'b0, CHAN_EVT[c].pulse_second};
      ev_second[c][`EQ_LATCH_BIT] = edge_sel_q[c][7]
        ? (live2_prev_q[c][`EQ_LIVE_BIT] && !CHAN_EVT[c].live_second[`EQ_LIVE_BIT])
        : (!live2_prev_q[c][`EQ_LIVE_BIT] && CHAN_EVT[c].live_second[`EQ_LIVE_BIT]);
      pend[c]   = (c < CHANNELS) && (|(latch_first_q[c] & en_first_q[c])
                                      || |(latch_second_q[c] & en_second_q[c]));
      new_ev[c] = (c < CHANNELS) && (|(ev_first[c] & en_first_q[c])
                                      || |(ev_second[c] & en_second_q[c]));
      rd_clr[c] = acc_rd && ch_sel[c] && (acc_addr[7:0] == `OFS_LATCH_FIRST
                                          || acc_addr[7:0] == `OFS_LATCH_SECOND);
    end
  end

  always_comb begin
    gp_level[0] = gen_pin_q[`GP_PIN0_DIRECTION_BIT] ? gen_pin_q[`GP_LVL0_BIT] : pin_s2_q.gen_pin[0];
    gp_level[1] = gen_pin_q[`GP_PIN1_DIRECTION_BIT] ? gen_pin_q[`GP_LVL1_BIT] : pin_s2_q.gen_pin[1];
  end

  always_comb begin
    rd_val = 8'h00;
    if (glob_hit) begin
      case (acc_addr[7:0])
        `OFS_GEN_PIN:      rd_val = {4'h0, gp_level, gen_pin_q[1:0]};
        `OFS_CHAN_SUMMARY: rd_val = summary_q;
        default:           rd_val = 8'h00;
      endcase
    end else if (|ch_sel) begin
      case (acc_addr[7:0])
        `OFS_LINE_STD:      rd_val = {7'h00, line_std_q[acc_addr[10:8]]};
        `OFS_IRQ_EN_FIRST:  rd_val = en_first_q[acc_addr[10:8]];
        `OFS_IRQ_EN_SECOND: rd_val = en_second_q[acc_addr[10:8]];
        `OFS_EDGE_SEL:      rd_val = edge_sel_q[acc_addr[10:8]];
        `OFS_LIVE_FIRST:    rd_val = CHAN_EVT[acc_addr[10:8]].live_first;
        `OFS_LIVE_SECOND:   rd_val = CHAN_EVT[acc_addr[10:8]].live_second;
        `OFS_LATCH_FIRST:   rd_val = latch_first_q[acc_addr[10:8]];
        `OFS_LATCH_SECOND:  rd_val = latch_second_q[acc_addr[10:8]];
        default:            rd_val = 8'h00;
      endcase
    end
  end

  // line standard survives soft reset
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      line_std_q <= {8{`RST_LINE_STD}};
    end else if (CE) begin
      for (int c = 0; c < 8; c++) begin
        if (acc_wr && ch_sel[c] && acc_addr[7:0] == `OFS_LINE_STD) begin
          line_std_q[c] <= acc_data[`LINE_STD_BIT];
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (core_rst) begin
      for (int c = 0; c < 8; c++) begin
        en_first_q[c]     <= `RST_IRQ_EN;
        en_second_q[c]    <= `RST_IRQ_EN;
        edge_sel_q[c]     <= `RST_EDGE_SEL;
        live1_prev_q[c]   <= CHAN_EVT[c].live_first;
        live2_prev_q[c]   <= CHAN_EVT[c].live_second;
        latch_first_q[c]  <= 8'h00;
        latch_second_q[c] <= 8'h00;
      end
    end else if (CE) begin
      for (int c = 0; c < 8; c++) begin
        live1_prev_q[c] <= CHAN_EVT[c].live_first;
        live2_prev_q[c] <= CHAN_EVT[c].live_second;
        // a new event in the clearing cycle stays latched
        latch_first_q[c]  <= (latch_first_q[c] & ~{8{rd_clr[c] && !acc_addr[0]}}) | ev_first[c];
        latch_second_q[c] <= (latch_second_q[c] & ~{8{rd_clr[c] && acc_addr[0]}}) | ev_second[c];
        if (acc_wr && ch_sel[c]) begin
          case (acc_addr[7:0])
            `OFS_IRQ_EN_FIRST:  en_first_q[c]  <= acc_data;
            `OFS_IRQ_EN_SECOND: en_second_q[c] <= acc_data;
            `OFS_EDGE_SEL:      edge_sel_q[c]  <= acc_data;
            default:            ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (core_rst) begin
      summary_q <= 8'h00;
      IRQ_N     <= 1'b1;
    end else if (CE) begin
      if (|pend) begin
        summary_q <= (summary_q & ~rd_clr) | new_ev;
      end else begin
        summary_q <= new_ev;
      end
      IRQ_N <= !(|pend);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (core_rst) begin
      gen_pin_q   <= `RST_GEN_PIN;
      GEN_PIN_OUT <= 2'h0;
      GEN_PIN_OE  <= 2'h0;
    end else if (CE) begin
      if (acc_wr && glob_hit && acc_addr[7:0] == `OFS_GEN_PIN) begin
        gen_pin_q <= acc_data[3:0];
      end
      GEN_PIN_OUT <= {gen_pin_q[`GP_LVL1_BIT], gen_pin_q[`GP_LVL0_BIT]};
      GEN_PIN_OE  <= {gen_pin_q[`GP_PIN1_DIRECTION_BIT], gen_pin_q[`GP_PIN0_DIRECTION_BIT]};
    end
  end

  // read answers: parallel bus directly, serial through the ack level
  always_ff @(posedge CLOCK) begin
    if (core_rst) begin
      D_OUT     <= 8'h00;
      rd_data_q <= 8'h00;
      rd_ack_q  <= 1'b0;
    end else if (CE) begin
      if (acc_rd && !serial_mode) begin
        D_OUT <= rd_val;
      end
      if (acc_rd && serial_mode) begin
        rd_data_q <= rd_val;
        rd_ack_q  <= 1'b1;
      end else if (!rd_req_sync_q[1]) begin
        rd_ack_q <= 1'b0;
      end
    end
  end

  assign LINE_STD = line_std_q;

endmodule // host_control_port

`default_nettype wire

//--- test/host_control_port_checker.sv
// pin-level assertions for the host control port, all on CLOCK
// assumes it is bound onto host_control_port with SETTLE_CYCLES handed on
`timescale 1ns/1ns
`default_nettype none

module host_control_port_checker #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic       CLOCK,
  input wire logic       RESET_N,
  input wire logic       SERIAL_SEL,
  input wire logic       STYLE_SEL,
  input wire logic       CS_N,
  input wire logic       SDO_OE,
  input wire logic       PCS_N,
  input wire logic       STROBE_N,
  input wire logic       RW_WR,
  input wire logic       D_OE,
  input wire logic       IRQ_N,
  input wire logic [1:0] GEN_PIN_OUT,
  input wire logic [1:0] GEN_PIN_OE,
  input wire logic [7:0] LINE_STD,
  input wire logic       DRIVER_HIZ
);
  // counts from pin reset release only
  logic [15:0] up_q;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      up_q <= 16'h0000;
    end else if (up_q != 16'hFFFF) begin
      up_q <= up_q + 16'h0001;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // ****************************************
  // sequences and assertions
  // ****************************************
  sequence quiet_s;
    PCS_N && CS_N;
  endsequence
  sequence par_rd_s;
    !SERIAL_SEL && !PCS_N && !STROBE_N && (RW_WR || STYLE_SEL);
  endsequence

  a_reset_idle: assert property ($rose(RESET_N) |-> IRQ_N && !D_OE && DRIVER_HIZ && GEN_PIN_OE == 2'h0)
    else $error("reset idle");
  a_hiz_settle: assert property (up_q < 16'(SETTLE_CYCLES) |-> DRIVER_HIZ)
    else $error("hiz early");
  a_hiz_drop: assert property (up_q == 16'(SETTLE_CYCLES + 4) |-> !DRIVER_HIZ)
    else $error("hiz late");
  a_serial_no_bus: assert property (SERIAL_SEL && $past(SERIAL_SEL, 4) |-> !D_OE)
    else $error("bus driven");
  a_frame_oe: assert property (CS_N && $past(CS_N) |-> !SDO_OE)
    else $error("sdo outside frame");
  a_read_drive: assert property (par_rd_s [*3] |=> D_OE)
    else $error("read unanswered");
  a_read_release: assert property ((PCS_N || STROBE_N) [*5] |-> !D_OE)
    else $error("bus held");
  a_irq_hold: assert property (quiet_s [*8] ##0 !IRQ_N |=> !IRQ_N)
    else $error("request dropped");
  a_pins_hold: assert property (quiet_s [*8] |=> $stable(GEN_PIN_OE) && $stable(GEN_PIN_OUT))
    else $error("pins changed");
  a_std_hold: assert property (quiet_s [*8] |=> $stable(LINE_STD))
    else $error("standard changed");
endmodule // host_control_port_checker

bind host_control_port host_control_port_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .SERIAL_SEL(SERIAL_SEL), .STYLE_SEL(STYLE_SEL),
  .CS_N(CS_N), .SDO_OE(SDO_OE), .PCS_N(PCS_N), .STROBE_N(STROBE_N), .RW_WR(RW_WR),
  .D_OE(D_OE), .IRQ_N(IRQ_N), .GEN_PIN_OUT(GEN_PIN_OUT), .GEN_PIN_OE(GEN_PIN_OE),
  .LINE_STD(LINE_STD), .DRIVER_HIZ(DRIVER_HIZ));

`default_nettype wire

//--- test/host_cpu_model.sv
// host model: straps, serial frames, parallel strobes
// assumes CLOCK is the core clock; serial bits run on their own 48 ns period
`timescale 1ns/1ns
`default_nettype none

module host_cpu_model (
  input  wire logic        CLOCK,
  input  wire logic        SDO,
  input  wire logic        SDO_OE,
  input  wire logic [7:0]  D_OUT,
  input  wire logic        D_OE,
  output var  logic        SERIAL_SEL,
  output var  logic        STYLE_SEL,
  output var  logic        SCLK,
  output var  logic        CS_N,
  output var  logic        SDI,
  output var  logic        PCS_N,
  output var  logic        STROBE_N,
  output var  logic        RW_WR,
  output var  logic [10:0] ADDR,
  output var  logic [7:0]  D_IN
);
  initial begin
    {SERIAL_SEL, STYLE_SEL, SCLK, SDI} = 4'h0;
    {CS_N, PCS_N, STROBE_N, RW_WR} = 4'hF;
    ADDR = 11'h000;
    D_IN = 8'h00;
  end

  // ****************************************
  // host accesses
  // ****************************************
  // straps move only while the port is idle
  task automatic mode(input logic ser, input logic sty);
    @(negedge CLOCK);
    SERIAL_SEL = ser;
    STYLE_SEL = sty;
    repeat (6) @(negedge CLOCK);
  endtask

  task automatic pwr(input logic [10:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    ADDR = a;
    D_IN = d;
    PCS_N = 1'b0;
    STROBE_N = STYLE_SEL;
    RW_WR = 1'b0;
    repeat (4) @(negedge CLOCK);
    {PCS_N, STROBE_N, RW_WR} = 3'h7;
    D_IN = ~d; // data inverted as the strobe ends
    repeat (5) @(negedge CLOCK);
  endtask

  task automatic prd(input logic [10:0] a, output logic [7:0] q, output logic ok);
    int n;
    @(negedge CLOCK);
    ADDR = a;
    PCS_N = 1'b0;
    STROBE_N = 1'b0;
    RW_WR = 1'b1;
    n = 0;
    while (D_OE !== 1'b1 && n < 10) begin
      @(negedge CLOCK);
      n++;
    end
    ok = (D_OE === 1'b1);
    q = D_OUT;
    {PCS_N, STROBE_N} = 2'h3;
    n = 0;
    while (D_OE !== 1'b0 && n < 10) begin
      @(negedge CLOCK);
      n++;
    end
    ok = ok && (D_OE === 1'b0);
    repeat (2) @(negedge CLOCK);
  endtask

  // the serial clock stands still low between frames
  task automatic spi(input logic rd, input logic [10:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [31:0] f;
    f = {rd, 4'h0, a, wd, 8'h00};
    q = 8'h00;
    #7;
    CS_N = 1'b0;
    for (int i = 0; i < (rd ? 32 : 24); i++) begin
      SDI = f[31 - i];
      #24;
      SCLK = 1'b1;
      if (i >= 24) q = {q[6:0], SDO_OE ? SDO : 1'bx};
      #24;
      SCLK = 1'b0;
    end
    #24;
    CS_N = 1'b1;
    SDI = ~SDI;
    #200;
  endtask
endmodule // host_cpu_model

`default_nettype wire

//--- test/host_control_port_tb.sv
// bench for the host control port
// assumes the checker file binds itself onto the design
`timescale 1ns/1ns
`default_nettype none

module host_control_port_tb
  import host_control_port_pkg::*;
;
  localparam int SETTLE = 8;
  logic            CLOCK, RESET_N, CE, SERIAL_SEL, STYLE_SEL, SCLK, CS_N, SDI, SDO, SDO_OE;
  logic            PCS_N, STROBE_N, RW_WR, D_OE, IRQ_N, DRIVER_HIZ, ok;
  logic [10:0]     ADDR;
  logic [7:0]      D_IN, D_OUT, LINE_STD, rq;
  logic [1:0]      GEN_PIN_IN, GEN_PIN_OUT, GEN_PIN_OE;
  chan_evt_s [7:0] evt;
  int              failures, n_compared;

  host_control_port #(.SETTLE_CYCLES(SETTLE)) u_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .CE(CE),
    .SERIAL_SEL(SERIAL_SEL), .STYLE_SEL(STYLE_SEL), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI), .SDO(SDO),
    .SDO_OE(SDO_OE), .PCS_N(PCS_N), .STROBE_N(STROBE_N), .RW_WR(RW_WR), .ADDR(ADDR), .D_IN(D_IN),
    .D_OUT(D_OUT), .D_OE(D_OE), .IRQ_N(IRQ_N), .GEN_PIN_IN(GEN_PIN_IN), .GEN_PIN_OUT(GEN_PIN_OUT),
    .GEN_PIN_OE(GEN_PIN_OE), .CHAN_EVT(evt), .LINE_STD(LINE_STD), .DRIVER_HIZ(DRIVER_HIZ));
  host_cpu_model u_host (.CLOCK(CLOCK), .SDO(SDO), .SDO_OE(SDO_OE), .D_OUT(D_OUT), .D_OE(D_OE),
    .SERIAL_SEL(SERIAL_SEL), .STYLE_SEL(STYLE_SEL), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI),
    .PCS_N(PCS_N), .STROBE_N(STROBE_N), .RW_WR(RW_WR), .ADDR(ADDR), .D_IN(D_IN));

  // ****************************************
  // checks and closing
  // ****************************************
  task automatic results;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic prd_chk(input logic [10:0] a, input logic [7:0] exp);
    u_host.prd(a, rq, ok);
    chk("read answered", 8'h01, {7'h00, ok});
    if (!ok) results();
    chk("read data", exp, rq);
  endtask

  task automatic spi_chk(input logic [10:0] a, input logic [7:0] exp);
    u_host.spi(1'b1, a, 8'hA5, rq);
    chk("serial read data", exp, rq);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (IRQ_N !== lvl && n < 8) begin
      @(negedge CLOCK);
      n++;
    end
    chk("request pin", {7'h00, lvl}, {7'h00, IRQ_N});
    if (IRQ_N !== lvl) results();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    @(negedge CLOCK);
    chk("request pin", 8'h01, {7'h00, IRQ_N});
    chk("drive enables", 8'h00, {5'h00, D_OE, GEN_PIN_OE});
    chk("driver hiz", 8'h01, {7'h00, DRIVER_HIZ});
    chk("line standard", 8'h00, LINE_STD);
    repeat (SETTLE + 4) @(negedge CLOCK);
    chk("driver hiz", 8'h00, {7'h00, DRIVER_HIZ});
  endtask

  task automatic t_gpio;
    u_host.mode(1'b0, 1'b0);
    u_host.pwr(11'h006, 8'h0F);
    chk("pin enables", 8'h03, {6'h00, GEN_PIN_OE});
    chk("pin levels", 8'h03, {6'h00, GEN_PIN_OUT});
    prd_chk(11'h006, 8'h0F);
    u_host.pwr(11'h006, 8'h01);
    chk("pin enables", 8'h01, {6'h00, GEN_PIN_OE});
    chk("pin0 level", 8'h00, {7'h00, GEN_PIN_OUT[0]});
    prd_chk(11'h006, 8'h09);
    u_host.mode(1'b0, 1'b1);
    prd_chk(11'h006, 8'h09);
    prd_chk(11'h004, 8'h00);
  endtask

  task automatic t_irq;
    u_host.pwr(11'h233, 8'h01);
    evt[2].live_first[0] = 1'b1;
    evt[5].pulse_second[0] = 1'b1;
    @(negedge CLOCK);
    evt[5].pulse_second[0] = 1'b0;
    wait_irq(1'b0);
    prd_chk(11'h009, 8'h04);
    prd_chk(11'h53B, 8'h01);
    wait_irq(1'b0);
    prd_chk(11'h23A, 8'h01);
    wait_irq(1'b1);
    prd_chk(11'h009, 8'h00);
    u_host.pwr(11'h235, 8'h01);
    evt[2].live_first[0] = 1'b0;
    wait_irq(1'b0);
    prd_chk(11'h23A, 8'h01);
    wait_irq(1'b1);
  endtask

  // every source kind of one masked channel at once
  task automatic t_kinds;
    evt[1] = '{live_first: 8'hFF, live_second: 8'h01, pulse_second: 7'h7F};
    @(negedge CLOCK);
    evt[1].pulse_second = 7'h00;
    repeat (2) @(negedge CLOCK);
    chk("request pin", 8'h01, {7'h00, IRQ_N});
    prd_chk(11'h136, 8'hFF);
    prd_chk(11'h13A, 8'h7F);
    prd_chk(11'h13B, 8'hFF);
    prd_chk(11'h13B, 8'h00);
  endtask

  task automatic t_serial;
    u_host.mode(1'b1, 1'b0);
    u_host.spi(1'b0, 11'h120, 8'h01, rq);
    spi_chk(11'h120, 8'h01);
    chk("line standard", 8'h02, LINE_STD);
    u_host.spi(1'b0, 11'h006, 8'h03, rq);
    spi_chk(11'h009, 8'h00);
    chk("pin enables", 8'h03, {6'h00, GEN_PIN_OE});
    u_host.spi(1'b0, 11'h004, 8'h5A, rq);
    repeat (10) @(negedge CLOCK);
    chk("driver hiz", 8'h01, {7'h00, DRIVER_HIZ});
    repeat (20) @(negedge CLOCK);
    chk("pin enables", 8'h00, {6'h00, GEN_PIN_OE});
    chk("line standard", 8'h02, LINE_STD);
    repeat (SETTLE + 4) @(negedge CLOCK);
    spi_chk(11'h120, 8'h01);
  endtask

  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  initial begin
    RESET_N = 1'b0;
    CE = 1'b1;
    GEN_PIN_IN = 2'b10;
    evt = '0;
    failures = 0;
    n_compared = 0;
    repeat (4) @(negedge CLOCK);
    RESET_N = 1'b1;
    t_reset();
    t_gpio();
    t_irq();
    t_kinds();
    t_serial();
    results();
  end
endmodule // host_control_port_tb

`default_nettype wire
